//--- verilog/dis_pkg.sv
// Constants, register map and types for the digital input scanner.
// Assumes a 100 MHz hclk and an AHB-Lite master with whole-word transfers.
package dis_pkg;

  // Channel counts: base card inputs first, add-on card channels follow
  localparam int DIS_BASE_N = 3;
  localparam int DIS_ADD_N  = 8;
  localparam int DIS_CH_N   = DIS_BASE_N + DIS_ADD_N;

  // Add-on channel measurement in whole volts, thresholds in whole volts
  localparam int DIS_VOLT_W = 9;
  localparam int DIS_THR_W  = 8;
  localparam logic [DIS_THR_W-1:0] DIS_ACT_RST = 8'h58;
  localparam logic [DIS_THR_W-1:0] DIS_REL_RST = 8'h3C;
  localparam logic [DIS_THR_W-1:0] DIS_AC_DIV  = 8'h0A;

  // Delays in milliseconds, up to 1800000 ms
  localparam int DIS_DLY_W = 21;
  localparam int DIS_TMR_W = 22;
  localparam logic [DIS_DLY_W-1:0] DIS_DLY_RST = 21'h000000;

  // Timing: time constants in their own unit, counts derived
  localparam int DIS_CLK_PERIOD_NS = 10;
  localparam int DIS_MS_NS         = 1000000;
  localparam int DIS_CYC_PER_MS    = DIS_MS_NS / DIS_CLK_PERIOD_NS;
  localparam int DIS_PRE_W         = 17;
  localparam int DIS_SCAN_PERIOD_MS = 5;
  localparam logic [2:0] DIS_SCAN_LAST = 3'(DIS_SCAN_PERIOD_MS - 1);
  localparam int DIS_AC_DROP_MS    = 30;
  localparam logic [DIS_TMR_W-1:0] DIS_AC_DROP = 22'(DIS_AC_DROP_MS);

  // Register map, byte addresses
  localparam logic [11:0] DIS_OFF_CFG   = 12'h000;
  localparam logic [11:0] DIS_OFF_PU    = 12'h040;
  localparam logic [11:0] DIS_OFF_DO    = 12'h080;
  localparam logic [11:0] DIS_OFF_ACT   = 12'h0C0;
  localparam logic [11:0] DIS_OFF_REL   = 12'h0E0;
  localparam logic [11:0] DIS_OFF_STAT  = 12'h100;
  localparam logic [3:0]  DIS_STAT_STATE = 4'h0;
  localparam logic [3:0]  DIS_STAT_LOGIC = 4'h1;
  localparam logic [3:0]  DIS_STAT_RELAY = 4'h2;
  localparam logic [3:0]  DIS_STAT_ENER  = 4'h3;

  // Configuration word fields
  localparam int DIS_CFG_NC = 0;
  localparam int DIS_CFG_AC = 1;

  localparam logic [1:0] DIS_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    DIS_RG_NONE,
    DIS_RG_CFG,
    DIS_RG_PU,
    DIS_RG_DO,
    DIS_RG_ACT,
    DIS_RG_REL,
    DIS_RG_STAT
  } dis_region_e;

endpackage

//--- verilog/dis_scanner.sv
// Digital input scanner: base card pins and add-on card voltage channels,
// with thresholds, polarity, delays and a three-stage scan pipeline.
// Assumes base pins are asynchronous; add-on voltages come from logic on hclk.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module dis_scanner #(
  parameter int unsigned CYC_PER_MS = dis_pkg::DIS_CYC_PER_MS
) (
  input  wire logic                                                   hclk,
  input  wire logic                                                   hresetn,
  input  wire logic                                                   hsel,
  input  wire logic [31:0]                                            haddr,
  input  wire logic [1:0]                                             htrans,
  input  wire logic                                                   hwrite,
  input  wire logic [2:0]                                             hsize,
  input  wire logic [31:0]                                            hwdata,
  input  wire logic                                                   hready,
  output logic      [31:0]                                            hrdata,
  output logic                                                        hreadyout,
  output logic                                                        hresp,
  input  wire logic [dis_pkg::DIS_BASE_N-1:0]                         base_pin,
  input  wire logic [dis_pkg::DIS_ADD_N-1:0][dis_pkg::DIS_VOLT_W-1:0] addon_volt,
  output logic      [dis_pkg::DIS_CH_N-1:0]                           binary_input_channel,
  output logic      [dis_pkg::DIS_CH_N-1:0]                           logic_state,
  output logic      [dis_pkg::DIS_CH_N-1:0]                           output_relay_channels
);
  import dis_pkg::*;
  localparam logic [DIS_PRE_W-1:0] PRE_LAST = DIS_PRE_W'(CYC_PER_MS - 1);
  function automatic dis_region_e dis_decode(input logic [31:0] a);
    dis_region_e r;
    logic [3:0]  i;
    r = DIS_RG_NONE;
    i = a[5:2];
    if (a[31:9] != '0 || a[1:0] != 2'b00) begin
      r = DIS_RG_NONE;
    end else if (a[8:6] == DIS_OFF_CFG[8:6] && i < 4'(DIS_CH_N)) begin
      r = DIS_RG_CFG;
    end else if (a[8:6] == DIS_OFF_PU[8:6] && i < 4'(DIS_CH_N)) begin
      r = DIS_RG_PU;
    end else if (a[8:6] == DIS_OFF_DO[8:6] && i < 4'(DIS_CH_N)) begin
      r = DIS_RG_DO;
    end else if (a[8:5] == DIS_OFF_ACT[8:5]) begin
      r = DIS_RG_ACT;
    end else if (a[8:5] == DIS_OFF_REL[8:5]) begin
      r = DIS_RG_REL;
    end else if (a[8:6] == DIS_OFF_STAT[8:6] && i <= DIS_STAT_ENER) begin
      r = DIS_RG_STAT;
    end
    return r;
  endfunction
  // Prescaler: millisecond base and scan tick
  logic [DIS_PRE_W-1:0] pre_reg, pre_next;
  logic [2:0]           scan_cnt_reg, scan_cnt_next;
  logic                 ms_tick_reg, ms_tick_next;
  logic                 scan_tick_reg, scan_tick_next;
  always_comb begin
    pre_next       = pre_reg;
    scan_cnt_next  = scan_cnt_reg;
    ms_tick_next   = 1'b0;
    scan_tick_next = 1'b0;
    if (pre_reg == PRE_LAST) begin
      pre_next     = '0;
      ms_tick_next = 1'b1;
      if (scan_cnt_reg == DIS_SCAN_LAST) begin
        scan_cnt_next  = '0;
        scan_tick_next = 1'b1;
      end else begin
        scan_cnt_next = scan_cnt_reg + 3'h1;
      end
    end else begin
      pre_next = pre_reg + DIS_PRE_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg       <= '0;
      scan_cnt_reg  <= '0;
      ms_tick_reg   <= 1'b0;
      scan_tick_reg <= 1'b0;
    end else begin
      pre_reg       <= pre_next;
      scan_cnt_reg  <= scan_cnt_next;
      ms_tick_reg   <= ms_tick_next;
      scan_tick_reg <= scan_tick_next;
    end
  end
  // Register file and AHB-Lite slave; reads take one wait state
  logic [1:0]           cfg_reg  [DIS_CH_N], cfg_next  [DIS_CH_N];
  logic [DIS_DLY_W-1:0] pu_reg   [DIS_CH_N], pu_next   [DIS_CH_N];
  logic [DIS_DLY_W-1:0] do_reg   [DIS_CH_N], do_next   [DIS_CH_N];
  logic [DIS_THR_W-1:0] act_reg  [DIS_ADD_N], act_next [DIS_ADD_N];
  logic [DIS_THR_W-1:0] rel_reg  [DIS_ADD_N], rel_next [DIS_ADD_N];
  logic                 wr_pend_reg, wr_pend_next;
  logic                 rd_pend_reg, rd_pend_next;
  logic [31:0]          addr_reg, addr_next;
  logic [31:0]          hrdata_reg, hrdata_next;
  logic                 hreadyout_reg, hreadyout_next;
  logic [DIS_CH_N-1:0]  state_reg, logic_reg, relay_reg, ener_reg;
  dis_region_e          wr_rg, rd_rg;
  logic                 accept;
  always_comb begin
    cfg_next       = cfg_reg;
    pu_next        = pu_reg;
    do_next        = do_reg;
    act_next       = act_reg;
    rel_next       = rel_reg;
    wr_pend_next   = 1'b0;
    rd_pend_next   = rd_pend_reg;
    addr_next      = addr_reg;
    hrdata_next    = hrdata_reg;
    hreadyout_next = hreadyout_reg;
    accept         = hsel && htrans == DIS_HTRANS_NONSEQ && hready;
    wr_rg          = dis_decode(addr_reg);
    rd_rg          = wr_rg;
    // Write data phase, completes with no wait state
    if (wr_pend_reg) begin
      case (wr_rg)
        DIS_RG_CFG: cfg_next[addr_reg[5:2]]  = hwdata[1:0];
        DIS_RG_PU:  pu_next[addr_reg[5:2]]   = hwdata[DIS_DLY_W-1:0];
        DIS_RG_DO:  do_next[addr_reg[5:2]]   = hwdata[DIS_DLY_W-1:0];
        DIS_RG_ACT: act_next[addr_reg[4:2]]  = hwdata[DIS_THR_W-1:0];
        DIS_RG_REL: rel_next[addr_reg[4:2]]  = hwdata[DIS_THR_W-1:0];
        default: ;
      endcase
    end
    // Read muxed one cycle after address phase so a preceding write is visible
    if (rd_pend_reg) begin
      hrdata_next = '0;
      case (rd_rg)
        DIS_RG_CFG: hrdata_next[1:0]           = cfg_reg[addr_reg[5:2]];
        DIS_RG_PU:  hrdata_next[DIS_DLY_W-1:0] = pu_reg[addr_reg[5:2]];
        DIS_RG_DO:  hrdata_next[DIS_DLY_W-1:0] = do_reg[addr_reg[5:2]];
        DIS_RG_ACT: hrdata_next[DIS_THR_W-1:0] = act_reg[addr_reg[4:2]];
        DIS_RG_REL: hrdata_next[DIS_THR_W-1:0] = rel_reg[addr_reg[4:2]];
        DIS_RG_STAT: begin
          if (addr_reg[5:2] == DIS_STAT_STATE) begin
            hrdata_next[DIS_CH_N-1:0] = state_reg;
          end else if (addr_reg[5:2] == DIS_STAT_LOGIC) begin
            hrdata_next[DIS_CH_N-1:0] = logic_reg;
          end else if (addr_reg[5:2] == DIS_STAT_RELAY) begin
            hrdata_next[DIS_CH_N-1:0] = relay_reg;
          end else begin
            hrdata_next[DIS_CH_N-1:0] = ener_reg;
          end
        end
        default: ;
      endcase
      rd_pend_next   = 1'b0;
      hreadyout_next = 1'b1;
    end
    if (accept) begin
      addr_next = haddr;
      if (hwrite) begin
        wr_pend_next = 1'b1;
      end else begin
        rd_pend_next   = 1'b1;
        hreadyout_next = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < DIS_CH_N; k++) begin
        cfg_reg[k] <= 2'h0;
        pu_reg[k]  <= DIS_DLY_RST;
        do_reg[k]  <= DIS_DLY_RST;
      end
      for (int k = 0; k < DIS_ADD_N; k++) begin
        act_reg[k] <= DIS_ACT_RST;
        rel_reg[k] <= DIS_REL_RST;
      end
      wr_pend_reg   <= 1'b0;
      rd_pend_reg   <= 1'b0;
      addr_reg      <= '0;
      hrdata_reg    <= '0;
      hreadyout_reg <= 1'b1;
    end else begin
      cfg_reg       <= cfg_next;
      pu_reg        <= pu_next;
      do_reg        <= do_next;
      act_reg       <= act_next;
      rel_reg       <= rel_next;
      wr_pend_reg   <= wr_pend_next;
      rd_pend_reg   <= rd_pend_next;
      addr_reg      <= addr_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= hreadyout_next;
    end
  end
  // Base card pins are asynchronous to hclk
  logic [DIS_BASE_N-1:0] sync1_reg, sync2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= base_pin;
      sync2_reg <= sync1_reg;
    end
  end
  // Per-channel detection, delay timing and commit
  logic [DIS_CH_N-1:0] ener_next, state_next, level;
  for (genvar k = 0; k < DIS_CH_N; k++) begin : g_ch
    logic [DIS_TMR_W-1:0] tmr_reg, tmr_next, target;
    if (k < DIS_BASE_N) begin : g_base
      always_comb begin
        ener_next[k] = sync2_reg[k];
      end
    end else begin : g_add
      logic [DIS_THR_W-1:0] rel_eff;
      always_comb begin
        // AC mode forces release to a tenth of activation
        rel_eff = cfg_reg[k][DIS_CFG_AC] ? act_reg[k-DIS_BASE_N] / DIS_AC_DIV : rel_reg[k-DIS_BASE_N];
        ener_next[k] = ener_reg[k];
        if (addon_volt[k-DIS_BASE_N] > {1'b0, act_reg[k-DIS_BASE_N]}) begin
          ener_next[k] = 1'b1;
        end else if (addon_volt[k-DIS_BASE_N] < {1'b0, rel_eff}) begin
          ener_next[k] = 1'b0;
        end
      end
    end

    always_comb begin
      level[k]  = ener_reg[k] ^ cfg_reg[k][DIS_CFG_NC];
      target    = state_reg[k]
                ? ({1'b0, do_reg[k]} + (cfg_reg[k][DIS_CFG_AC] ? DIS_AC_DROP : '0))
                : {1'b0, pu_reg[k]};
      tmr_next  = tmr_reg;
      state_next[k] = state_reg[k];
      // Timer runs only while the level disagrees with the committed state
      if (level[k] == state_reg[k]) begin
        tmr_next = '0;
      end else if (ms_tick_reg && tmr_reg != '1) begin
        tmr_next = tmr_reg + DIS_TMR_W'(1);
      end
      if (scan_tick_reg && level[k] != state_reg[k] && tmr_reg >= target) begin
        state_next[k] = level[k];
        tmr_next      = '0;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        tmr_reg <= '0;
      end else begin
        tmr_reg <= tmr_next;
      end
    end
  end
  // Scan pipeline: input state, internal logic, relay command
  logic [DIS_CH_N-1:0] logic_next, relay_next;
  always_comb begin
    logic_next = logic_reg;
    relay_next = relay_reg;
    if (scan_tick_reg) begin
      logic_next = state_reg;
      relay_next = logic_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ener_reg  <= '0;
      state_reg <= '0;
      logic_reg <= '0;
      relay_reg <= '0;
    end else begin
      ener_reg  <= ener_next;
      state_reg <= state_next;
      logic_reg <= logic_next;
      relay_reg <= relay_next;
    end
  end

  assign hrdata                = hrdata_reg;
  assign hreadyout             = hreadyout_reg;
  assign hresp                 = 1'b0;
  assign binary_input_channel  = state_reg;
  assign logic_state           = logic_reg;
  assign output_relay_channels = relay_reg;
endmodule

//--- verif/dis_field.sv
// Field side model: base card contacts and add-on card voltage sources.
// Assumes the bench sets the commands; contacts move off the clock edge.
`timescale 1ns/1ps
module dis_field (
  input  wire logic                                                   hclk,
  input  wire logic [dis_pkg::DIS_BASE_N-1:0]                         pin_cmd,
  input  wire logic [dis_pkg::DIS_ADD_N-1:0][dis_pkg::DIS_VOLT_W-1:0] volt_cmd,
  output logic      [dis_pkg::DIS_BASE_N-1:0]                         base_pin,
  output logic      [dis_pkg::DIS_ADD_N-1:0][dis_pkg::DIS_VOLT_W-1:0] addon_volt
);
  import dis_pkg::*;
  // Real contacts have no relation to hclk
  // Continuous so the contacts are defined 3 ns after time zero, never X after that
  assign #3 base_pin = pin_cmd;
  always_ff @(posedge hclk) addon_volt <= volt_cmd;
endmodule

//--- verif/dis_scanner_chk.sv
// Checker for the scanner: bus wait states and the scan pipeline.
// Assumes it is bound to dis_scanner and sees only its ports.
`timescale 1ns/1ps
module dis_scanner_chk #(
  parameter int unsigned CYC_PER_MS = 10
) (
  input wire logic                         hclk,
  input wire logic                         hresetn,
  input wire logic                         hsel,
  input wire logic [1:0]                   htrans,
  input wire logic                         hwrite,
  input wire logic                         hready,
  input wire logic [31:0]                  hrdata,
  input wire logic                         hreadyout,
  input wire logic                         hresp,
  input wire logic [dis_pkg::DIS_CH_N-1:0] binary_input_channel,
  input wire logic [dis_pkg::DIS_CH_N-1:0] logic_state,
  input wire logic [dis_pkg::DIS_CH_N-1:0] output_relay_channels
);
  import dis_pkg::*;
  localparam int SCAN_CYC = DIS_SCAN_PERIOD_MS * CYC_PER_MS;
  logic [DIS_CH_N-1:0] prev_reg;
  int                  gap_reg;
  int                  gap_next;
  logic                take;
  assign take = hsel && htrans == DIS_HTRANS_NONSEQ && hready;
  // Saturates so the first change after reset is always legal
  always_comb begin
    gap_next = (gap_reg < SCAN_CYC) ? gap_reg + 1 : gap_reg;
    if (binary_input_channel != prev_reg) begin
      gap_next = 0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= '0;
      gap_reg  <= SCAN_CYC;
    end else begin
      prev_reg <= binary_input_channel;
      gap_reg  <= gap_next;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_spacing; $changed(binary_input_channel) |-> gap_reg >= SCAN_CYC - 1; endproperty
  property p_logic; $changed(logic_state) |-> logic_state == $past(binary_input_channel); endproperty
  property p_relay; $changed(output_relay_channels) |-> output_relay_channels == $past(logic_state); endproperty
  property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  property p_wr_wait; take && hwrite |=> hreadyout; endproperty
  property p_low_once; !hreadyout |=> hreadyout; endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_rdata; $changed(hrdata) |-> $past(hreadyout) == 1'b0; endproperty
  a_spacing: assert property (p_spacing) else $error("state changed twice within one scan");
  a_logic: assert property (p_logic) else $error("logic view is not last state");
  a_relay: assert property (p_relay) else $error("relay command is not last logic view");
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_wait: assert property (p_wr_wait) else $error("write stalled");
  a_low_once: assert property (p_low_once) else $error("ready low too long");
  a_okay: assert property (p_okay) else $error("error response");
  a_rdata: assert property (p_rdata) else $error("read data moved outside a read");
  c_state: cover property ($changed(binary_input_channel));
  c_relay: cover property ($changed(output_relay_channels));
  c_read: cover property (take && !hwrite);
endmodule

//--- verif/dis_tb.sv
// Self-checking bench for the digital input scanner.
// Assumes dis_pkg, dis_scanner, dis_field and dis_scanner_chk are compiled first.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  import dis_pkg::*;
  localparam int unsigned CPM  = 10;
  localparam int          SCAN = DIS_SCAN_PERIOD_MS * CPM;
  logic                                  hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]                           haddr, hwdata, hrdata, rd;
  logic [1:0]                            htrans;
  logic [2:0]                            hsize;
  logic [DIS_BASE_N-1:0]                 base_pin, pin_cmd;
  logic [DIS_ADD_N-1:0][DIS_VOLT_W-1:0]  addon_volt, volt_cmd;
  logic [DIS_CH_N-1:0]                   st, lg, rly;
  int                                    num_errors = 0, n_compared = 0, cyc = 0;
  assign hready = hreadyout;
  dis_field u_field (.hclk(hclk), .pin_cmd(pin_cmd), .volt_cmd(volt_cmd), .base_pin(base_pin),
    .addon_volt(addon_volt));
  dis_scanner #(.CYC_PER_MS(CPM)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .base_pin(base_pin), .addon_volt(addon_volt),
    .binary_input_channel(st), .logic_state(lg), .output_relay_channels(rly));
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Entered just after a rising edge; returns at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    htrans <= DIS_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    `CHK(nm, exp, rd)
  endtask
  task automatic wait_ms(input int n);
    repeat (n * CPM) @(posedge hclk);
  endtask
  // Bounded wait: a state that never arrives shows up in the following compare
  task automatic wait_st(input logic [DIS_CH_N-1:0] m, input logic [DIS_CH_N-1:0] v);
    for (int k = 0; k < 3 * SCAN && (st & m) !== v; k++) @(posedge hclk);
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("[FAIL] run length expected 40000 seen longer");
      wrap_up();
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pin_cmd = '0;
    volt_cmd = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("act0", DIS_OFF_ACT, 32'h58);
    rdchk("rel7", DIS_OFF_REL + 12'h01C, 32'h3C);
    rdchk("pu10", DIS_OFF_PU + 12'h028, 32'h0);
    rdchk("unmapped", 12'hFF0, 32'h0);
    bus(1'b1, DIS_OFF_STAT, 32'h7FF);
    rdchk("stat_ro", DIS_OFF_STAT, 32'h0);
    for (int j = 0; j < DIS_ADD_N; j++) volt_cmd[j] <= 9'd88;
    wait_ms(12);
    `CHK("at_act", 11'h000, st)
    for (int j = 0; j < DIS_ADD_N; j++) volt_cmd[j] <= 9'd89;
    wait_st(11'h7FF, 11'h7F8);
    `CHK("addon_all", 11'h7F8, st)
    `CHK("logic_lag", 11'h000, lg)
    repeat (SCAN) @(posedge hclk);
    `CHK("logic_on", 11'h7F8, lg)
    `CHK("relay_lag", 11'h000, rly)
    repeat (SCAN) @(posedge hclk);
    `CHK("relay_on", 11'h7F8, rly)
    for (int j = 0; j < DIS_ADD_N; j++) volt_cmd[j] <= 9'd60;
    wait_ms(12);
    `CHK("hold", 11'h7F8, st)
    for (int j = 0; j < DIS_ADD_N; j++) volt_cmd[j] <= 9'd59;
    wait_st(11'h7FF, 11'h000);
    `CHK("release", 11'h000, st)
    bus(1'b1, DIS_OFF_CFG + 12'h010, 32'h1);
    wait_st(11'h010, 11'h010);
    `CHK("nc_idle", 11'h010, st)
    bus(1'b1, DIS_OFF_ACT + 12'h008, 32'd100);
    bus(1'b1, DIS_OFF_REL + 12'h008, 32'd50);
    volt_cmd[2] <= 9'd100;
    wait_ms(12);
    `CHK("thr_eq", 11'h010, st)
    volt_cmd[2] <= 9'd101;
    wait_st(11'h020, 11'h020);
    `CHK("thr_up", 11'h030, st)
    // Status view: channel 4 idle but inverted, channel 5 energized
    rdchk("stat_state", DIS_OFF_STAT, 32'h030);
    rdchk("stat_ener", DIS_OFF_STAT + 12'h00C, 32'h020);
    rdchk("cfg4", DIS_OFF_CFG + 12'h010, 32'h1);
    bus(1'b1, DIS_OFF_DO + 12'h028, 32'hFFFFFFFF);
    rdchk("do10", DIS_OFF_DO + 12'h028, 32'h001FFFFF);
    repeat (2 * SCAN) @(posedge hclk);
    rdchk("stat_logic", DIS_OFF_STAT + 12'h004, 32'h030);
    rdchk("stat_relay", DIS_OFF_STAT + 12'h008, 32'h030);
    bus(1'b1, DIS_OFF_PU, 32'd20);
    pin_cmd[0] <= 1'b1;
    wait_ms(10);
    pin_cmd[0] <= 1'b0;
    wait_ms(30);
    `CHK("pulse_drop", 1'b0, st[0])
    pin_cmd[0] <= 1'b1;
    wait_ms(18);
    `CHK("pu_early", 1'b0, st[0])
    wait_st(11'h001, 11'h001);
    `CHK("pu_done", 1'b1, st[0])
    bus(1'b1, DIS_OFF_CFG + 12'h004, 32'h2);
    pin_cmd[1] <= 1'b1;
    wait_st(11'h002, 11'h002);
    pin_cmd[1] <= 1'b0;
    wait_ms(28);
    `CHK("ac_hold", 1'b1, st[1])
    wait_st(11'h002, 11'h000);
    `CHK("ac_drop", 1'b0, st[1])
    wrap_up();
  end
endmodule
bind dis_scanner dis_scanner_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .binary_input_channel(binary_input_channel), .logic_state(logic_state),
  .output_relay_channels(output_relay_channels));
